// ### rtl/clock_timer_pkg.sv
package clock_timer_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned MACHINE_CLOCK_HZ = 12500000;
  localparam int unsigned HALF_CYCLE_COUNT = CLK_HZ / (2 * MACHINE_CLOCK_HZ);
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLE_COUNT - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
  localparam logic OE_DRIVE_N = 1'h0;
endpackage : clock_timer_pkg

// ### rtl/pulse_if.sv
`timescale 1ns/1ps
interface pulse_if;
  logic rise_en;
  logic underflow;
  logic pulse;
  modport shaper (input rise_en, input underflow, output pulse);
  modport top (output rise_en, output underflow, input pulse);
endinterface : pulse_if

// ### rtl/timer_pulse_shaper.sv
`timescale 1ns/1ps
module timer_pulse_shaper
  import clock_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pulse_if.shaper link
);
  logic pending_q;
  logic pulse_q;
  logic pending_d;

  // A new underflow in the launch cycle stays pending, so none is lost
  assign pending_d = link.underflow | (pending_q & ~link.rise_en);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_q <= 1'h0;
      pulse_q <= 1'h0;
    end else begin
      pending_q <= pending_d;
      if (link.rise_en) begin
        pulse_q <= pending_q; // RULE_12
      end
    end
  end

  assign link.pulse = pulse_q;
endmodule : timer_pulse_shaper

// ### rtl/clock_timer_pin_control.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Machine clock output toggles at machine-cycle rate; cycles start on rising edges.
// RULE_02 - Global output-disable low puts machine clock output in high impedance.
// RULE_03 - Clock-mode select inputs are captured while reset is low, initialising mode.
// RULE_04 - After reset release software may overwrite the clock mode.
// RULE_05 - Select input changes after reset release are ignored until next reset.
// RULE_06 - Oscillator input pin serves as clock source when internal oscillator unused.
// RULE_07 - Crystal drive output stays driven even while outputs are disabled.
// RULE_08 - Timer A underflow gives a pulse on the first timer output pin.
// RULE_09 - Timer B underflow gives a pulse one machine clock cycle wide.
// RULE_10 - Timer B pulse shares pin with host-port interrupt; shown only when port disabled.
// RULE_11 - Output-disable low puts both timer output pins in high impedance.
// RULE_12 - Timer pulses start on a machine clock rising edge, end on the next.
module clock_timer_pin_control
  import clock_timer_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic RESET_N,
  input wire logic [MODE_W-1:0] CLOCK_MODE_SELECT,
  input wire logic SW_MODE_WRITE,
  input wire logic [MODE_W-1:0] SW_MODE_VALUE,
  input wire logic OUTPUT_DISABLE_N,
  input wire logic OSCILLATOR_INPUT,
  input wire logic INTERNAL_OSC_ENABLE,
  input wire logic TIMER_A_UNDERFLOW,
  input wire logic TIMER_B_UNDERFLOW,
  input wire logic HOST_PORT_ENABLE,
  input wire logic HOST_PORT_INTERRUPT_IN,
  output logic MACHINE_CLOCK_OUT,
  output logic MACHINE_CLOCK_OUT_OE_N,
  output logic CRYSTAL_DRIVE_OUT,
  output logic CRYSTAL_DRIVE_OUT_OE_N,
  output logic TIMER_A_PULSE_OUT,
  output logic TIMER_A_PULSE_OUT_OE_N,
  output logic TIMER_B_PULSE_OUT,
  output logic TIMER_B_PULSE_OUT_OE_N,
  output logic [MODE_W-1:0] CLOCK_MODE,
  output logic CLOCK_SOURCE
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic mclk_q;
  logic [MODE_W-1:0] mode_q;
  logic [MODE_W-1:0] mode_d;
  logic crystal_q;
  logic source_q;
  logic shared_q;
  wire div_end;
  wire rise_en;
  wire pre_rise_en;
  wire disabled;

  pulse_if timer_a_link ();
  pulse_if timer_b_link ();

  assign div_end = (div_q == DIV_LAST);
  assign div_d = div_end ? DIV_RESET : div_q + 4'h1;
  // The enable marks the CLK edge on which the machine clock goes high
  assign rise_en = div_end & ~mclk_q;
  // One CLK ahead of the rise, so the registered shared pin lines up with the machine clock edge
  assign pre_rise_en = (div_q == DIV_LAST - 4'h1) & ~mclk_q;
  assign disabled = ~OUTPUT_DISABLE_N;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      div_q <= DIV_RESET;
      mclk_q <= 1'h0;
    end else begin
      div_q <= div_d;
      if (div_end) begin
        mclk_q <= ~mclk_q; // RULE_01
      end
    end
  end

  // Reset pin level wins; software writes count only once reset is released
  assign mode_d = ~RESET_N ? CLOCK_MODE_SELECT : // RULE_03
                  SW_MODE_WRITE ? SW_MODE_VALUE : // RULE_04
                  mode_q; // RULE_05

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_q <= MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Inverting drive models the crystal amplifier; idle low when unused
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      crystal_q <= 1'h0;
      source_q <= 1'h0;
    end else begin
      crystal_q <= INTERNAL_OSC_ENABLE & ~OSCILLATOR_INPUT;
      source_q <= OSCILLATOR_INPUT; // RULE_06
    end
  end

  assign timer_a_link.rise_en = rise_en;
  assign timer_a_link.underflow = TIMER_A_UNDERFLOW;
  assign timer_b_link.rise_en = pre_rise_en; // RULE_12
  assign timer_b_link.underflow = TIMER_B_UNDERFLOW;

  timer_pulse_shaper timer_a_shaper (
    .clk(CLK),
    .rst(SYS_RST),
    .link(timer_a_link.shaper)
  );

  timer_pulse_shaper timer_b_shaper (
    .clk(CLK),
    .rst(SYS_RST),
    .link(timer_b_link.shaper)
  );

  // Registered so the shared pin carries no mux glitch
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shared_q <= 1'h0;
    end else begin
      shared_q <= HOST_PORT_ENABLE ? HOST_PORT_INTERRUPT_IN : timer_b_link.pulse; // RULE_10
    end
  end

  assign MACHINE_CLOCK_OUT = mclk_q;
  assign MACHINE_CLOCK_OUT_OE_N = disabled; // RULE_02
  assign CRYSTAL_DRIVE_OUT = crystal_q;
  assign CRYSTAL_DRIVE_OUT_OE_N = OE_DRIVE_N; // RULE_07
  assign TIMER_A_PULSE_OUT = timer_a_link.pulse; // RULE_08
  assign TIMER_A_PULSE_OUT_OE_N = disabled; // RULE_11
  // Host interrupt lags its input by one CLK; the timer pulse still spans one machine cycle
  assign TIMER_B_PULSE_OUT = shared_q; // RULE_09
  assign TIMER_B_PULSE_OUT_OE_N = disabled; // RULE_11
  assign CLOCK_MODE = mode_q;
  assign CLOCK_SOURCE = source_q;
endmodule : clock_timer_pin_control

// ### test/ext_clock_source.sv
`timescale 1ns/1ps
// Board oscillator stand-in: runs free at half the system rate
module ext_clock_source (
  input wire logic CLK,
  output logic OSC
);
  logic osc_q = 1'h0;
  always @(posedge CLK) osc_q <= ~osc_q;
  assign OSC = osc_q;
endmodule : ext_clock_source

// ### test/clock_timer_pin_control_chk.sv
`timescale 1ns/1ps
module clock_timer_pin_control_chk (
  input logic CLK, SYS_RST, RESET_N, SW_MODE_WRITE, OUTPUT_DISABLE_N, HOST_PORT_ENABLE, HOST_PORT_INTERRUPT_IN,
  input logic INTERNAL_OSC_ENABLE, OSCILLATOR_INPUT, CLOCK_SOURCE, MACHINE_CLOCK_OUT, MACHINE_CLOCK_OUT_OE_N,
  input logic TIMER_A_PULSE_OUT, TIMER_A_PULSE_OUT_OE_N, TIMER_B_PULSE_OUT, TIMER_B_PULSE_OUT_OE_N,
  input logic [2:0] CLOCK_MODE_SELECT, SW_MODE_VALUE, CLOCK_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_pulse(sig); $rose(MACHINE_CLOCK_OUT) ##0 sig [*4]; endsequence
  property p_mclk; $rose(MACHINE_CLOCK_OUT) |-> ##2 $fell(MACHINE_CLOCK_OUT) ##2 $rose(MACHINE_CLOCK_OUT); endproperty
  a_mclk: assert property (p_mclk) else $error("clock period");
  property p_oe;
    {MACHINE_CLOCK_OUT_OE_N, TIMER_A_PULSE_OUT_OE_N, TIMER_B_PULSE_OUT_OE_N} == {3{!OUTPUT_DISABLE_N}};
  endproperty
  a_oe: assert property (p_oe) else $error("enable");
  property p_cap; !RESET_N |=> CLOCK_MODE == $past(CLOCK_MODE_SELECT); endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_sw; RESET_N && SW_MODE_WRITE |=> CLOCK_MODE == $past(SW_MODE_VALUE); endproperty
  a_sw: assert property (p_sw) else $error("write");
  property p_hold; RESET_N && !SW_MODE_WRITE |=> $stable(CLOCK_MODE); endproperty
  a_hold: assert property (p_hold) else $error("mode hold");
  property p_src; !INTERNAL_OSC_ENABLE |=> CLOCK_SOURCE == $past(OSCILLATOR_INPUT); endproperty
  a_src: assert property (p_src) else $error("source");
  property p_pulse; $rose(TIMER_A_PULSE_OUT) |-> s_pulse(TIMER_A_PULSE_OUT); endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_pulse_b;
    $rose(TIMER_B_PULSE_OUT) && !$past(HOST_PORT_ENABLE) |-> s_pulse(TIMER_B_PULSE_OUT || $past(HOST_PORT_ENABLE));
  endproperty
  a_pulse_b: assert property (p_pulse_b) else $error("pulse b");
  property p_host_port_interrupt_out; HOST_PORT_ENABLE |=> TIMER_B_PULSE_OUT == $past(HOST_PORT_INTERRUPT_IN); endproperty
  a_host_port_interrupt_out: assert property (p_host_port_interrupt_out) else $error("shared pin");
endmodule : clock_timer_pin_control_chk
bind clock_timer_pin_control clock_timer_pin_control_chk clock_timer_pin_control_chk_i (.*);

// ### test/tb_clock_timer_pin_control.sv
`timescale 1ns/1ps
`define CHK(n,e,s) begin num_checks++; if ((s)!==(e)) begin fail_count++; $display("[ERR] %s exp %h got %h",n,e,s); end end
module tb_clock_timer_pin_control;
  logic CLK = 0, SYS_RST = 1, RESET_N = 0, SW_MODE_WRITE = 0, OUTPUT_DISABLE_N = 1, INTERNAL_OSC_ENABLE = 0;
  logic TIMER_A_UNDERFLOW = 0, TIMER_B_UNDERFLOW = 0, HOST_PORT_ENABLE = 0, HOST_PORT_INTERRUPT_IN = 0;
  logic [2:0] CLOCK_MODE_SELECT = 3'h5, SW_MODE_VALUE = 3'h0;
  wire MACHINE_CLOCK_OUT, MACHINE_CLOCK_OUT_OE_N, CRYSTAL_DRIVE_OUT, CRYSTAL_DRIVE_OUT_OE_N, CLOCK_SOURCE;
  wire TIMER_A_PULSE_OUT, TIMER_A_PULSE_OUT_OE_N, TIMER_B_PULSE_OUT, TIMER_B_PULSE_OUT_OE_N, OSCILLATOR_INPUT;
  wire [2:0] CLOCK_MODE;
  wire [3:0] oe_n = {MACHINE_CLOCK_OUT_OE_N, TIMER_A_PULSE_OUT_OE_N, TIMER_B_PULSE_OUT_OE_N, CRYSTAL_DRIVE_OUT_OE_N};
  int fail_count = 0, num_checks = 0, cyc = 0, na, nb;
  always #10 CLK = ~CLK;
  clock_timer_pin_control clock_timer_pin_control_i (.*);
  ext_clock_source ext_clock_source_i (.CLK(CLK), .OSC(OSCILLATOR_INPUT));
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge CLK) if (++cyc > 400) begin
    fail_count++;
    print_verdict;
  end
  task t_mode;
    @(negedge CLK) `CHK("mode", 3'h5, CLOCK_MODE)
    RESET_N = 1;
    CLOCK_MODE_SELECT = 3'h2;
    repeat (2) @(negedge CLK);
    `CHK("mode", 3'h5, CLOCK_MODE)
    SW_MODE_WRITE = 1;
    SW_MODE_VALUE = 3'h3;
    @(negedge CLK) SW_MODE_WRITE = 0;
    `CHK("mode", 3'h3, CLOCK_MODE)
    RESET_N = 0;
    @(negedge CLK) RESET_N = 1;
    `CHK("mode", 3'h2, CLOCK_MODE)
  endtask : t_mode
  task t_timer;
    {TIMER_A_UNDERFLOW, TIMER_B_UNDERFLOW} = 2'h3;
    @(negedge CLK) {TIMER_A_UNDERFLOW, TIMER_B_UNDERFLOW} = 2'h0;
    repeat (8) if (TIMER_A_PULSE_OUT !== 1'h1) @(negedge CLK);
    `CHK("edge", 1'h1, MACHINE_CLOCK_OUT)
    `CHK("edge_b", 1'h1, TIMER_B_PULSE_OUT)
    {na, nb} = 0;
    repeat (6) begin
      na += TIMER_A_PULSE_OUT;
      nb += TIMER_B_PULSE_OUT;
      @(negedge CLK);
    end
    `CHK("a_len", 4, na)
    `CHK("b_len", 4, nb)
    {HOST_PORT_ENABLE, HOST_PORT_INTERRUPT_IN, TIMER_B_UNDERFLOW} = 3'h7;
    @(negedge CLK) TIMER_B_UNDERFLOW = 0;
    @(negedge CLK) `CHK("shared", 1'h1, TIMER_B_PULSE_OUT)
    HOST_PORT_INTERRUPT_IN = 0;
    repeat (6) @(negedge CLK) `CHK("shared", 1'h0, TIMER_B_PULSE_OUT)
  endtask : t_timer
  task t_osc;
    logic osc_seen;
    INTERNAL_OSC_ENABLE = 1;
    repeat (4) begin
      @(negedge CLK) osc_seen = OSCILLATOR_INPUT;
      @(negedge CLK) `CHK("source", osc_seen, CLOCK_SOURCE)
      `CHK("crystal", ~osc_seen, CRYSTAL_DRIVE_OUT)
    end
    INTERNAL_OSC_ENABLE = 0;
    @(negedge CLK) `CHK("crystal", 1'h0, CRYSTAL_DRIVE_OUT)
  endtask : t_osc
  task t_oe;
    @(negedge CLK) OUTPUT_DISABLE_N = 0;
    #1 `CHK("oe_n", 4'hE, oe_n)
    @(negedge CLK) OUTPUT_DISABLE_N = 1;
    #1 `CHK("oe_n", 4'h0, oe_n)
  endtask : t_oe
  initial begin
    repeat (9) @(negedge CLK);
    SYS_RST = 0;
    t_mode;
    t_timer;
    t_osc;
    t_oe;
    print_verdict;
  end
endmodule : tb_clock_timer_pin_control
